// ==== hw/cfg_decode_cfg.svh ====
// Offsets, field masks, reset values and codes of the function 1 config decode.
// Assumes inclusion by bare name from design and bench files.
`ifndef CFG_DECODE_CFG_SVH
`define CFG_DECODE_CFG_SVH

// ==========================================================
// Bus codes
`define CMD_CFG_READ   4'hA
`define CMD_CFG_WRITE  4'hB
`define FUNC_THIS      3'h1
`define AD_LOW_ZERO    2'h0

// ==========================================================
// Dword indexes in the header
`define IDX_ID         6'h00
`define IDX_CMDSTAT    6'h01
`define IDX_CLASS      6'h02
`define IDX_HDR        6'h03
`define IDX_BAR0       6'h04
`define IDX_SUBSYS     6'h0B
`define IDX_HDR_END    6'h10

// ==========================================================
// Field masks and fixed values
`define CMD_RW_MASK    32'h0000_0146
`define STAT_W1C_MASK  32'hF900_0000
`define STAT_RO_VAL    32'h0280_0000
`define HDR_TYPE_VAL   8'h80
`define LAT_RW_MASK    32'h0000_FF00
`define BAR_RW_MASK    32'hFFFF_F000
`define BAR_RO_VAL     32'h0000_0008
`define NO_W1C         32'h0000_0000
`define REG_RESET      32'h0000_0000
`define CLASS_VAL      24'h04_8000

`endif

// ==== hw/cfg_decode_pkg.sv ====
// Types shared by the function 1 config decode files.
// Assumes nothing beyond a SystemVerilog compiler.
package cfg_decode_pkg;

   // ==========================================================
   // Status events raised by other device logic, one-cycle pulses
   typedef struct packed {
      logic parity_detected;
      logic serr_signaled;
      logic master_abort_rcvd;
      logic target_abort_rcvd;
      logic target_abort_sig;
      logic parity_reported;
   } pci_events_t;

   // ==========================================================
   // Control levels handed to the rest of the function
   typedef struct packed {
      logic        mem_space_en;
      logic        bus_master_en;
      logic        parity_resp_en;
      logic        serr_en;
      logic        disconnected;
      logic [7:0]  latency_timer;
      logic [19:0] bar_base;
   } cfg_ctrl_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DECODE, ST_WAIT, ST_XFER, ST_TURN
   } cfg_state_t;

endpackage : cfg_decode_pkg

// ==== hw/cfg_word_merge.sv ====
// Next value of one 32-bit configuration word under a byte-enabled write.
// Assumes set pulses come from logic on the same clock.
`timescale 1ns/100ps
module cfg_word_merge #(
   parameter logic [31:0] RW_MASK  = 32'h0000_0000,
   parameter logic [31:0] W1C_MASK = 32'h0000_0000
) (
   // Current word and write
   input  wire logic [31:0] cur,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  be,
   input  wire logic        we,
   // Hardware set bits
   input  wire logic [31:0] set,
   // Result
   output logic      [31:0] next_word
);
   logic [31:0] lane;
   logic [31:0] kept;

   always_comb begin
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & {32{we}};
      kept = (cur & ~(lane & RW_MASK)) | (wdata & lane & RW_MASK);
      kept = kept & ~(lane & wdata & W1C_MASK);
      // Set after clear, so a same-cycle event survives
      next_word = (kept | (set & W1C_MASK)) & (RW_MASK | W1C_MASK);
   end

endmodule : cfg_word_merge

// ==== hw/pci_function1_config_decode.sv ====
// Configuration-cycle target for the second PCI function: decode, header
// read mux, and the writable command, status, latency and base words.
// Assumes all bus pins are synchronous to clk (the PCI clock).
`timescale 1ns/100ps
`include "cfg_decode_cfg.svh"
module pci_function1_config_decode #(
   parameter logic [15:0] VENDOR_CODE = 16'h1AB0, // arbitrary
   parameter logic [15:0] DEVICE_CODE = 16'h0001, // arbitrary
   parameter logic [7:0]  REVISION    = 8'h01,    // arbitrary
   parameter logic [15:0] SUBSYS_VEND = 16'h0000, // arbitrary
   parameter logic [15:0] SUBSYS_ID   = 16'h0000  // arbitrary
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // PCI target pins
   input  wire logic                       frame_n,
   input  wire logic                       irdy_n,
   input  wire logic                       idsel,
   input  wire logic [3:0]                 cbe_n,
   input  wire logic [31:0]                ad_in,
   output logic      [31:0]                ad_out,
   output logic                            ad_oe,
   output logic                            devsel_n,
   output logic                            trdy_n,
   output logic                            ctl_oe,
   // Status events from the rest of the device
   input  wire cfg_decode_pkg::pci_events_t events,
   // Control levels to the rest of the function
   output cfg_decode_pkg::cfg_ctrl_t       ctrl
);
   import cfg_decode_pkg::*;

   // ==========================================================
   // Address phase decode
   cfg_state_t  state;
   logic        frame_prev;
   logic        addr_phase;
   logic        claim;
   logic        is_write;
   logic [5:0]  index;
   logic [3:0]  be;
   logic        xfer_done;
   logic        wr_now;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frame_prev <= 1'b1;
      end else begin
         frame_prev <= frame_n;
      end
   end

   assign addr_phase = !frame_n && frame_prev;

   // Command, IDSEL and low bits separate config from memory cycles
   assign claim = addr_phase && idsel
                  && ad_in[1:0] == `AD_LOW_ZERO
                  && ad_in[10:8] == `FUNC_THIS
                  && (cbe_n == `CMD_CFG_READ || cbe_n == `CMD_CFG_WRITE);

   assign xfer_done = state == ST_XFER && !irdy_n;
   assign be        = ~cbe_n;
   assign wr_now    = xfer_done && is_write;

   // ==========================================================
   // Target sequence, medium decode
   // Command enables never gate this path: config always answers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (claim) begin
                  state <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               state <= ST_XFER;
            end
            ST_XFER: begin
               if (xfer_done) begin
                  state <= frame_n ? ST_TURN : ST_WAIT;
               end
            end
            ST_TURN: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Dword index, one wait state per phase keeps read data registered
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         index    <= 6'h00;
         is_write <= 1'b0;
      end else if (state == ST_IDLE && claim) begin
         index    <= ad_in[7:2];
         is_write <= cbe_n == `CMD_CFG_WRITE;
      end else if (xfer_done) begin
         index    <= index + 6'h01;
      end
   end

   // ==========================================================
   // Writable words
   logic [31:0] cmdstat;
   logic [31:0] lat_word;
   logic [31:0] bar_word;
   logic [31:0] next_cmdstat;
   logic [31:0] next_lat;
   logic [31:0] next_bar;
   logic [31:0] status_set;

   assign status_set = {events.parity_detected, events.serr_signaled,
                        events.master_abort_rcvd, events.target_abort_rcvd,
                        events.target_abort_sig, 2'b00,
                        events.parity_reported, 24'h00_0000};

   cfg_word_merge #(
      .RW_MASK  (`CMD_RW_MASK),
      .W1C_MASK (`STAT_W1C_MASK)
   ) u_cmdstat (
      .cur       (cmdstat),
      .wdata     (ad_in),
      .be        (be),
      .we        (wr_now && index == `IDX_CMDSTAT),
      .set       (status_set),
      .next_word (next_cmdstat)
   );

   cfg_word_merge #(
      .RW_MASK  (`LAT_RW_MASK),
      .W1C_MASK (`NO_W1C)
   ) u_lat (
      .cur       (lat_word),
      .wdata     (ad_in),
      .be        (be),
      .we        (wr_now && index == `IDX_HDR),
      .set       (`REG_RESET),
      .next_word (next_lat)
   );

   // Low bits of the base read fixed, not as written
   cfg_word_merge #(
      .RW_MASK  (`BAR_RW_MASK),
      .W1C_MASK (`NO_W1C)
   ) u_bar (
      .cur       (bar_word),
      .wdata     (ad_in),
      .be        (be),
      .we        (wr_now && index == `IDX_BAR0),
      .set       (`REG_RESET),
      .next_word (next_bar)
   );

   // Status bits set, cleared by one, kept by zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmdstat <= `REG_RESET;
      end else begin
         cmdstat <= next_cmdstat;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lat_word <= `REG_RESET;
         bar_word <= `REG_RESET;
      end else begin
         lat_word <= next_lat;
         bar_word <= next_bar;
      end
   end

   // ==========================================================
   // Read mux
   logic [31:0] rd_word;

   always_comb begin
      unique case (index)
         `IDX_ID:      rd_word = {DEVICE_CODE, VENDOR_CODE};
         `IDX_CMDSTAT: rd_word = cmdstat | `STAT_RO_VAL;
         `IDX_CLASS:   rd_word = {`CLASS_VAL, REVISION};
         `IDX_HDR:     rd_word = {8'h00, `HDR_TYPE_VAL, lat_word[15:8], 8'h00};
         `IDX_BAR0:    rd_word = bar_word | `BAR_RO_VAL;
         `IDX_SUBSYS:  rd_word = {SUBSYS_ID, SUBSYS_VEND};
         // Absent words and all beyond 64 bytes read zero
         default:      rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ad_out <= 32'h0000_0000;
      end else if (state == ST_WAIT) begin
         ad_out <= rd_word;
      end
   end

   // ==========================================================
   // Pin drive
   always_comb begin
      devsel_n = !(state == ST_WAIT || state == ST_XFER);
      trdy_n   = state != ST_XFER;
      ctl_oe   = state == ST_WAIT || state == ST_XFER || state == ST_TURN;
      ad_oe    = !is_write && state == ST_XFER;
   end

   // ==========================================================
   // Control levels
   always_comb begin
      ctrl.mem_space_en   = cmdstat[1];
      ctrl.bus_master_en  = cmdstat[2];
      ctrl.parity_resp_en = cmdstat[6];
      ctrl.serr_en        = cmdstat[8];
      ctrl.disconnected   = cmdstat[15:0] == 16'h0000;
      ctrl.latency_timer  = lat_word[15:8];
      ctrl.bar_base       = bar_word[31:12];
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence seq_claim_start;
      state == ST_IDLE && claim;
   endsequence

   sequence seq_medium_devsel;
      state == ST_DECODE && devsel_n ##1 !devsel_n && trdy_n;
   endsequence

   AST_CLAIM_MEDIUM: assert property (
      seq_claim_start |=> seq_medium_devsel)
      else $error("claimed cycle missed medium devsel");

   AST_LOW_BITS_IGNORED: assert property (
      state == ST_IDLE && addr_phase && ad_in[1:0] != `AD_LOW_ZERO
      |=> state == ST_IDLE && devsel_n)
      else $error("cycle with nonzero low bits claimed");

   AST_OTHER_FUNC: assert property (
      state == ST_IDLE && addr_phase && ad_in[10:8] != `FUNC_THIS
      |=> (state == ST_IDLE) [*3])
      else $error("other function answered");

   AST_BURST_ADVANCE: assert property (
      xfer_done && !frame_n
      |=> index == $past(index) + 6'h01 && state == ST_WAIT ##1 !trdy_n)
      else $error("burst did not advance");

   AST_RESERVED_ZERO: assert property (
      state == ST_WAIT && index >= `IDX_HDR_END |=> ad_out == 32'h0000_0000)
      else $error("reserved word read nonzero");

   AST_HDR_TYPE: assert property (
      state == ST_WAIT && index == `IDX_HDR |=> ad_out[23:16] == `HDR_TYPE_VAL)
      else $error("header type wrong");

   AST_W1C_CLEAR: assert property (
      wr_now && index == `IDX_CMDSTAT && be[3] && ad_in[31]
      && !events.parity_detected |=> !cmdstat[31])
      else $error("status bit not cleared by one");

   AST_RO_WRITE_DROPPED: assert property (
      wr_now && index >= `IDX_HDR_END && status_set == 32'h0000_0000
      |=> $stable(cmdstat) && $stable(lat_word) && $stable(bar_word))
      else $error("write outside header changed state");

   // Turnaround drives both controls high, then lets go
   sequence seq_turnaround;
      state == ST_TURN && ctl_oe && devsel_n && trdy_n && !ad_oe ##1 !ctl_oe;
   endsequence

   AST_LAST_PHASE_TURN: assert property (
      xfer_done && frame_n |=> seq_turnaround)
      else $error("last phase did not release the bus");

   AST_READ_DRIVE: assert property (
      state == ST_XFER && !is_write |-> ad_oe && !devsel_n && !trdy_n)
      else $error("read data phase not driven");

   AST_CONFIG_WHEN_OFF: assert property (
      state == ST_IDLE && claim && ctrl.disconnected |=> state == ST_DECODE)
      else $error("config cycle refused while disconnected");

   AST_BAR_LOW_FIXED: assert property (
      state == ST_WAIT && index == `IDX_BAR0
      |=> (ad_out & ~`BAR_RW_MASK) == `BAR_RO_VAL)
      else $error("base low bits not fixed");

endmodule : pci_function1_config_decode

// ==== tb/cfg_host_model.sv ====
// Host bridge model that issues configuration cycles, single or burst.
// Assumes the bench fills wq, calls xfer and reads rq by hierarchy.
`timescale 1ns/100ps
`include "cfg_decode_cfg.svh"
module cfg_host_model (
   // Clock
   input  wire logic        clk,
   // Host driven pins
   output logic             frame_n,
   output logic             irdy_n,
   output logic             idsel,
   output logic [3:0]       cbe_n,
   output logic [31:0]      ad_in,
   // Target pins
   input  wire logic [31:0] ad_out,
   input  wire logic        ad_oe,
   input  wire logic        devsel_n,
   input  wire logic        trdy_n,
   input  wire logic        ctl_oe
);
   logic [31:0] ad_drv;
   logic [31:0] wq [16];
   logic [31:0] rq [16];

   // Released AD shows the inverse of the last value, never a held copy
   assign ad_in = ad_oe ? ad_out : ad_drv;

   initial begin
      frame_n = 1'b1;
      irdy_n  = 1'b1;
      idsel   = 1'b0;
      cbe_n   = 4'hF;
      ad_drv  = 32'h0000_0000;
   end

   // ==========
   // One transaction; refused after 8 edges with no target ready
   task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [2:0] func,
                       input logic [5:0] idx, input logic [1:0] low, input int n,
                       input logic [3:0] be, output logic claimed);
      int i;
      int k;
      claimed = 1'b1;
      @(negedge clk);
      frame_n = 1'b0;
      idsel   = sel;
      cbe_n   = cmd;
      ad_drv  = {21'h0, func, idx, low};
      @(negedge clk);
      idsel   = 1'b0;
      irdy_n  = 1'b0;
      cbe_n   = ~be;
      frame_n = (n == 1);
      ad_drv  = (cmd == `CMD_CFG_WRITE) ? wq[0] : ~ad_drv;
      for (i = 0; i < n && claimed; i++) begin
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (!(ctl_oe === 1'b1 && trdy_n === 1'b0) && k < 8);
         claimed = (ctl_oe === 1'b1 && devsel_n === 1'b0 && trdy_n === 1'b0);
         rq[i] = ad_in;
         @(negedge clk);
         if (claimed && i < n - 1) begin
            frame_n = (i + 2 == n);
            ad_drv  = (cmd == `CMD_CFG_WRITE) ? wq[i+1] : ~ad_drv;
         end
      end
      frame_n = 1'b1;
      irdy_n  = 1'b1;
      cbe_n   = 4'hF;
      ad_drv  = ~ad_drv;
      repeat (2) @(negedge clk);
   endtask : xfer
endmodule : cfg_host_model

// ==== tb/tb.sv ====
// Self-checking bench for the function 1 configuration decode.
// Assumes the host model drives the bus; events are pulsed between cycles.
`timescale 1ns/100ps
`include "cfg_decode_cfg.svh"
module tb;
   import cfg_decode_pkg::*;
   // Arbitrary identity values
   localparam logic [15:0] VEN = 16'h2C3D;
   localparam logic [15:0] DEV = 16'h0042;
   localparam logic [7:0]  REV = 8'h07;
   localparam logic [15:0] SSV = 16'h3E5F;
   localparam logic [15:0] SSI = 16'h0A0B;

   logic        clk, rst_n, frame_n, irdy_n, idsel, ad_oe, devsel_n, trdy_n, ctl_oe;
   logic [3:0]  cbe_n;
   logic [31:0] ad_in, ad_out, m_cs, m_hdr, m_bar;
   pci_events_t events;
   cfg_ctrl_t   ctrl;
   int          fail_count, n_compared;
   int          seed = 40019;

   pci_function1_config_decode #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV), .REVISION(REV),
      .SUBSYS_VEND(SSV), .SUBSYS_ID(SSI)) DUT (.clk(clk), .rst_n(rst_n),
      .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .cbe_n(cbe_n), .ad_in(ad_in),
      .ad_out(ad_out), .ad_oe(ad_oe), .devsel_n(devsel_n), .trdy_n(trdy_n),
      .ctl_oe(ctl_oe), .events(events), .ctrl(ctrl));
   cfg_host_model host (.clk(clk), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel),
      .cbe_n(cbe_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .devsel_n(devsel_n), .trdy_n(trdy_n), .ctl_oe(ctl_oe));

   always #20 clk = ~clk;

   // ==========
   // Expected state
   function automatic logic [31:0] merge(logic [31:0] o, wd, m, rw, w1c);
      return ((o & ~(m & rw)) | (wd & m & rw)) & ~(wd & m & w1c);
   endfunction : merge

   function automatic logic [31:0] exp_reg(int idx);
      case (idx)
         `IDX_ID:     return {DEV, VEN};
         `IDX_CMDSTAT: return m_cs | `STAT_RO_VAL;
         `IDX_CLASS:  return {`CLASS_VAL, REV};
         `IDX_HDR:    return {8'h00, `HDR_TYPE_VAL, m_hdr[15:8], 8'h00};
         `IDX_BAR0:   return m_bar | `BAR_RO_VAL;
         `IDX_SUBSYS: return {SSI, SSV};
         default:     return 32'h0000_0000;
      endcase
   endfunction : exp_reg

   function automatic cfg_ctrl_t exp_ctrl();
      return {m_cs[1], m_cs[2], m_cs[6], m_cs[8], m_cs[15:0] == 16'h0000,
              m_hdr[15:8], m_bar[31:12]};
   endfunction : exp_ctrl

   // ==========
   // Compare and run control
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_ctrl();
      n_compared++;
      if (ctrl !== exp_ctrl()) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, ctrl, exp_ctrl());
      end
   endtask : chk_ctrl

   task automatic finish_test();
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   task automatic wr_burst(input int idx, input int n, input logic [3:0] be);
      logic cl;
      logic [31:0] m;
      host.xfer(`CMD_CFG_WRITE, 1'b1, `FUNC_THIS, 6'(idx), `AD_LOW_ZERO, n, be, cl);
      chk({31'h0, cl}, 32'h1);
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      for (int i = 0; i < n; i++) begin
         if (idx + i == 1) m_cs = merge(m_cs, host.wq[i], m, `CMD_RW_MASK, `STAT_W1C_MASK);
         if (idx + i == 3) m_hdr = merge(m_hdr, host.wq[i], m, `LAT_RW_MASK, `NO_W1C);
         if (idx + i == 4) m_bar = merge(m_bar, host.wq[i], m, `BAR_RW_MASK, `NO_W1C);
      end
   endtask : wr_burst

   task automatic rd_check(input int idx, input int n);
      logic cl;
      host.xfer(`CMD_CFG_READ, 1'b1, `FUNC_THIS, 6'(idx), `AD_LOW_ZERO, n, 4'hF, cl);
      chk({31'h0, cl}, 32'h1);
      for (int i = 0; i < n; i++) chk(host.rq[i], exp_reg(idx + i));
   endtask : rd_check

   initial begin
      #(20000 * 40);
      fail_count++;
      finish_test();
   end

   // ==========
   // Main sequence
   initial begin
      int          idx, n, kind;
      logic        cl;
      logic [31:0] r;
      clk = 1'b0;
      rst_n = 1'b0;
      events = '0;
      {m_cs, m_hdr, m_bar} = '0;
      fail_count = 0;
      n_compared = 0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      chk_ctrl();
      rd_check(0, 16);
      for (int i = 0; i < 6; i++) rd_check(16 + ($unsigned($random(seed)) % 48), 1);
      for (int t = 0; t < 60; t++) begin
         r = $random(seed);
         if (r[8]) begin
            @(negedge clk);
            events = r[5:0];
            m_cs = m_cs | {r[5:1], 2'b00, r[0], 24'h0};
            @(negedge clk);
            events = '0;
         end
         idx = $unsigned($random(seed)) % 18;
         n = 1 + $unsigned($random(seed)) % 3;
         for (int i = 0; i < n; i++) host.wq[i] = $random(seed);
         wr_burst(idx, n, r[15:12]);
         chk_ctrl();
         rd_check(idx, n);
      end
      host.wq[0] = 32'hFFFF_0000;
      wr_burst(1, 1, 4'hF);
      chk_ctrl();
      rd_check(1, 1);
      for (int k = 0; k < 12; k++) begin
         kind = k % 4;
         r = $random(seed);
         host.wq[0] = $random(seed);
         host.xfer((kind == 3) ? {1'b0, r[2:0]} : `CMD_CFG_WRITE, kind != 0,
                   (kind == 2) ? ((r[5:3] == 3'h1) ? 3'h0 : r[5:3]) : `FUNC_THIS,
                   6'(1 + k % 4), (kind == 1) ? ((r[7:6] == 2'h0) ? 2'h3 : r[7:6]) : 2'h0,
                   1, 4'hF, cl);
         chk({31'h0, cl}, 32'h0);
         rd_check(1, 4);
      end
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      {m_cs, m_hdr, m_bar} = '0;
      chk_ctrl();
      rd_check(1, 4);
      finish_test();
   end
endmodule : tb
